// ### iord_bank.sv
// Register bank end: decodes I/O and data-space views onto the 64 I/O registers.
// Assumes pins and peripheral events arrive as plain inputs on mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "iord_regs.svh"
module iord_bank
    import iord_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    iord_link_if.bank link,
    input wire logic [7:0] pin_b_i,
    input wire logic [7:0] pin_c_i,
    input wire logic [7:0] pin_d_i,
    input wire logic [3:0] pin_a_i,
    input wire logic [2:0] t0_event_i,
    input wire logic [3:0] t1_event_i,
    input wire logic [1:0] spi_status_i,
    output logic [7:0] dir_b_o,
    output logic [7:0] out_b_o,
    output logic [7:0] dir_c_o,
    output logic [7:0] out_c_o,
    output logic [7:0] dir_d_o,
    output logic [7:0] out_d_o,
    output logic [3:0] dir_a_o,
    output logic [3:0] out_a_o,
    output logic [7:0] ext_addr_o,
    output logic ext_we_o,
    output logic ext_re_o,
    output logic [7:0] ext_wdata_o,
    input wire logic [7:0] ext_rdata_i
);
    // Whole state of the bank: storage for 64 locations, pin sampling stages and levels, plus answer outputs.
    typedef struct packed {
        logic [63:0][7:0] regs;
        logic [2:0][7:0] pb_s;
        logic [2:0][7:0] pc_s;
        logic [2:0][7:0] pd_s;
        logic [2:0][3:0] pa_s;
        logic [7:0] pb_v; // Port B level once two stages agree.
        logic [7:0] pc_v; // Port C level once two stages agree.
        logic [7:0] pd_v; // Port D level once two stages agree.
        logic [3:0] pa_v; // Port A level once two stages agree.
        logic [7:0] rdata;
        logic bit_val;
        logic ack;
        logic err;
    } iord_bank_state_type;

    iord_bank_state_type state_reg;
    iord_bank_state_type state_next;

    // Mask of implemented, software-writable bits for one location.
    function automatic logic [7:0] iord_wmask(input logic [5:0] a);
        if (a == `IORD_OUTA || a == `IORD_DIRA) iord_wmask = `IORD_MASK_PA;
        else if (a == `IORD_DIRB || a == `IORD_OUTB || a == `IORD_DIRC) iord_wmask = 8'hFF;
        else if (a == `IORD_OUTC || a == `IORD_DIRD || a == `IORD_OUTD) iord_wmask = 8'hFF;
        else if (a == `IORD_PCTL || a == `IORD_SCR0 || a == `IORD_NVMDAT) iord_wmask = 8'hFF;
        else if (a == `IORD_NVMADR || a == `IORD_T0CNT || a == `IORD_T0CMPA) iord_wmask = 8'hFF;
        else if (a == `IORD_T0CMPB || a == `IORD_SCR1 || a == `IORD_SCR2) iord_wmask = 8'hFF;
        else if (a == `IORD_SPCTL) iord_wmask = 8'hFF;
        else if (a == `IORD_NVMCTL) iord_wmask = `IORD_MASK_NVMCTL;
        else if (a == `IORD_GTSYNC) iord_wmask = `IORD_MASK_GTSYNC;
        else if (a == `IORD_T0CTL) iord_wmask = `IORD_MASK_T0CTL;
        else if (a == `IORD_SPSTAT) iord_wmask = `IORD_MASK_SPSTAT_RW;
        else iord_wmask = 8'h00;
    endfunction : iord_wmask

    // Mask of write-one-to-clear flag bits for one location.
    function automatic logic [7:0] iord_w1c(input logic [5:0] a);
        if (a == `IORD_T0FLG) iord_w1c = `IORD_MASK_T0FLG;
        else if (a == `IORD_T1FLG) iord_w1c = `IORD_MASK_T1FLG;
        else iord_w1c = 8'h00;
    endfunction : iord_w1c

    // Takes a pin bit only where the second and third stages agree, so a glitch is dropped.
    function automatic logic [7:0] iord_agree(input logic [7:0] s1, input logic [7:0] s2,
        input logic [7:0] old);
        iord_agree = (s2 & ~(s1 ^ s2)) | (old & (s1 ^ s2));
    endfunction : iord_agree

    // Read view of one location: storage, sampled pins or hardware status.
    function automatic logic [7:0] iord_read(input iord_bank_state_type s, input logic [5:0] a);
        if (a == `IORD_LVLB) iord_read = s.pb_v;
        else if (a == `IORD_LVLC) iord_read = s.pc_v;
        else if (a == `IORD_LVLD) iord_read = s.pd_v;
        else if (a == `IORD_LVLA) iord_read = {4'h0, s.pa_v};
        else iord_read = s.regs[a] & (iord_wmask(a) | iord_w1c(a)
            | ((a == `IORD_SPSTAT) ? `IORD_MASK_SPSTAT_RO : 8'h00));
    endfunction : iord_read

    // Decode of the request into an I/O location or the extended region.
    logic is_io_op;
    logic is_ds_op;
    logic ds_in_io;
    logic ds_in_ext;
    logic [5:0] loc;
    logic [7:0] ds_loc;

    always_comb
    begin
        is_io_op = link.op == IORD_OP_IN || link.op == IORD_OP_OUT
            || link.op == IORD_OP_SETBIT || link.op == IORD_OP_CLRBIT
            || link.op == IORD_OP_SKIPTEST;
        is_ds_op = link.op == IORD_OP_LOAD || link.op == IORD_OP_STORE;
        ds_loc = link.addr - `IORD_DS_OFFSET;
        ds_in_io = link.addr >= `IORD_DS_OFFSET && ds_loc <= `IORD_IO_LAST;
        ds_in_ext = link.addr >= `IORD_EXT_FIRST;
        loc = is_ds_op ? ds_loc[5:0] : link.addr[5:0];
    end

    // Extended region is passed through, for load and store only.
    always_comb
    begin
        ext_addr_o = link.addr;
        ext_wdata_o = link.wdata;
        ext_we_o = link.req && link.op == IORD_OP_STORE && ds_in_ext;
        ext_re_o = link.req && link.op == IORD_OP_LOAD && ds_in_ext;
    end

    // Next-state logic: pin sampling, software access, then flag capture.
    always_comb
    begin
        logic [7:0] cur;
        logic [7:0] wm;
        logic [7:0] cm;
        logic [7:0] bm;
        logic wr;
        logic [7:0] wv;
        cur = 8'h00;
        wm = 8'h00;
        cm = 8'h00;
        bm = 8'h00;
        wr = 1'b0;
        wv = 8'h00;
        state_next = state_reg;
        state_next.pb_s = {state_reg.pb_s[1:0], pin_b_i};
        state_next.pc_s = {state_reg.pc_s[1:0], pin_c_i};
        state_next.pd_s = {state_reg.pd_s[1:0], pin_d_i};
        state_next.pa_s = {state_reg.pa_s[1:0], pin_a_i};
        // A pin level counts only once the second and third stages agree.
        state_next.pb_v = iord_agree(state_reg.pb_s[1], state_reg.pb_s[2], state_reg.pb_v);
        state_next.pc_v = iord_agree(state_reg.pc_s[1], state_reg.pc_s[2], state_reg.pc_v);
        state_next.pd_v = iord_agree(state_reg.pd_s[1], state_reg.pd_s[2], state_reg.pd_v);
        state_next.pa_v = 4'(iord_agree({4'h0, state_reg.pa_s[1]}, {4'h0, state_reg.pa_s[2]},
            {4'h0, state_reg.pa_v}));
        state_next.ack = link.req;
        state_next.err = 1'b0;
        state_next.bit_val = 1'b0;
        state_next.rdata = 8'h00;
        cur = iord_read(state_reg, loc);
        wm = iord_wmask(loc);
        cm = iord_w1c(loc);
        bm = 8'h01 << link.bit_sel;
        if (link.req)
        begin
            if (is_io_op && link.addr > `IORD_IO_LAST)
            begin
                state_next.err = 1'b1;
            end
            else if ((link.op == IORD_OP_SETBIT || link.op == IORD_OP_CLRBIT
                || link.op == IORD_OP_SKIPTEST) && link.addr > `IORD_BIT_LAST)
            begin
                state_next.err = 1'b1;
            end
            else if (is_ds_op && ds_in_ext)
            begin
                state_next.rdata = ext_rdata_i;
            end
            else if (is_ds_op && !ds_in_io)
            begin
                state_next.err = 1'b1;
            end
            else if (link.op == IORD_OP_SKIPTEST)
            begin
                state_next.bit_val = cur[link.bit_sel];
            end
            else if (link.op == IORD_OP_IN || link.op == IORD_OP_LOAD)
            begin
                state_next.rdata = cur;
            end
            else if (link.op == IORD_OP_OUT || link.op == IORD_OP_STORE)
            begin
                wr = 1'b1;
                wv = link.wdata;
            end
            else if (link.op == IORD_OP_SETBIT || link.op == IORD_OP_CLRBIT)
            begin
                // Only the addressed bit is written; other flags see zero.
                wr = 1'b1;
                wv = (link.op == IORD_OP_SETBIT) ? bm : 8'h00;
                wm = wm & bm;
                cm = cm & bm;
            end
        end
        // Plain bits take written data; flags clear on one, zero leaves them.
        if (wr)
        begin
            state_next.regs[loc] = (state_reg.regs[loc] & ~wm) | (wv & wm);
            state_next.regs[loc] = state_next.regs[loc] & ~(wv & cm);
        end
        // Hardware events set flags after the clear, so a set wins.
        state_next.regs[`IORD_T0FLG][2:0] = state_next.regs[`IORD_T0FLG][2:0] | t0_event_i;
        state_next.regs[`IORD_T1FLG][5] = state_next.regs[`IORD_T1FLG][5] | t1_event_i[3];
        state_next.regs[`IORD_T1FLG][2:0] = state_next.regs[`IORD_T1FLG][2:0] | t1_event_i[2:0];
        state_next.regs[`IORD_SPSTAT][7:6] = spi_status_i;
    end

    // State register.
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from state.
    always_comb
    begin
        link.rdata = state_reg.rdata;
        link.bit_val = state_reg.bit_val;
        link.ack = state_reg.ack;
        link.err = state_reg.err;
        dir_b_o = state_reg.regs[`IORD_DIRB];
        out_b_o = state_reg.regs[`IORD_OUTB];
        dir_c_o = state_reg.regs[`IORD_DIRC];
        out_c_o = state_reg.regs[`IORD_OUTC];
        dir_d_o = state_reg.regs[`IORD_DIRD];
        out_d_o = state_reg.regs[`IORD_OUTD];
        dir_a_o = state_reg.regs[`IORD_DIRA][3:0];
        out_a_o = state_reg.regs[`IORD_OUTA][3:0];
    end
endmodule : iord_bank
`default_nettype wire

// ### iord_regs.svh
// Offsets, field positions and reset values of the I/O register space.
// Assumes inclusion from the package and the two ends; definitions only.
`ifndef IORD_REGS_SVH
`define IORD_REGS_SVH
`define IORD_DS_OFFSET 8'h20
`define IORD_IO_LAST 8'h3F
`define IORD_BIT_LAST 8'h1F
`define IORD_EXT_FIRST 8'h60
`define IORD_LVLB 6'h03
`define IORD_DIRB 6'h04
`define IORD_OUTB 6'h05
`define IORD_LVLC 6'h06
`define IORD_DIRC 6'h07
`define IORD_OUTC 6'h08
`define IORD_LVLD 6'h09
`define IORD_DIRD 6'h0A
`define IORD_OUTD 6'h0B
`define IORD_LVLA 6'h0C
`define IORD_DIRA 6'h0D
`define IORD_OUTA 6'h0E
`define IORD_PCTL 6'h12
`define IORD_T0FLG 6'h15
`define IORD_T1FLG 6'h16
`define IORD_SCR0 6'h1E
`define IORD_NVMCTL 6'h1F
`define IORD_NVMDAT 6'h20
`define IORD_NVMADR 6'h21
`define IORD_GTSYNC 6'h24
`define IORD_T0CTL 6'h25
`define IORD_T0CNT 6'h26
`define IORD_T0CMPA 6'h27
`define IORD_T0CMPB 6'h28
`define IORD_SCR1 6'h2A
`define IORD_SCR2 6'h2B
`define IORD_SPCTL 6'h2C
`define IORD_SPSTAT 6'h2D
`define IORD_MASK_PA 8'h0F
`define IORD_MASK_T0FLG 8'h07
`define IORD_MASK_T1FLG 8'h27
`define IORD_MASK_NVMCTL 8'h3F
`define IORD_MASK_GTSYNC 8'h81
`define IORD_MASK_T0CTL 8'h0F
`define IORD_MASK_SPSTAT_RW 8'h01
`define IORD_MASK_SPSTAT_RO 8'hC0
`define IORD_RESET_VALUE 8'h00
`endif

// ### iord_pkg.sv
// Types shared by both ends of the I/O register access link.
// Assumes iord_regs.svh sits in the same folder.
`default_nettype none
`include "iord_regs.svh"
package iord_pkg;
    // Kind of access the core presents.
    typedef enum logic [2:0] {
        IORD_OP_NONE = 3'b000,
        IORD_OP_IN = 3'b001,
        IORD_OP_OUT = 3'b010,
        IORD_OP_LOAD = 3'b011,
        IORD_OP_STORE = 3'b100,
        IORD_OP_SETBIT = 3'b101,
        IORD_OP_CLRBIT = 3'b110,
        IORD_OP_SKIPTEST = 3'b111
    } iord_op_type;
endpackage : iord_pkg
`default_nettype wire

// ### iord_link_if.sv
// Link between the processor core end and the register bank end.
// Assumes both ends share mclk_i; one request per cycle, answer next cycle.
`timescale 1ns/1ps
`default_nettype none
interface iord_link_if;
    import iord_pkg::*;
    iord_op_type op; // Access kind, valid while req is high.
    logic req; // Request strobe, one cycle.
    logic [7:0] addr; // I/O address for IN/OUT/bit ops, data address for load/store.
    logic [2:0] bit_sel; // Bit number for bit ops.
    logic [7:0] wdata; // Write data.
    logic [7:0] rdata; // Read data, from flip-flop.
    logic bit_val; // Current value of the tested bit, from flip-flop.
    logic ack; // Answer strobe, one cycle after req.
    logic err; // Access refused, with ack.
    modport core (output op, req, addr, bit_sel, wdata, input rdata, bit_val, ack, err);
    modport bank (input op, req, addr, bit_sel, wdata, output rdata, bit_val, ack, err);
endinterface : iord_link_if
`default_nettype wire

// ### iord_core_end.sv
// Core end: turns user commands into link requests and returns answers.
// Assumes iord_bank on the same clock answers every request one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "iord_regs.svh"
module iord_core_end
    import iord_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    iord_link_if.core link,
    input wire logic cmd_valid_i,
    input wire iord_op_type cmd_op_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [2:0] cmd_bit_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic skip_o,
    output logic err_o
);
    // Whole state: outstanding flag, held request and captured answer.
    typedef struct packed {
        logic busy;
        iord_op_type op;
        logic want; // Wanted bit level of a skip test, kept from the take.
        logic [7:0] rdata;
        logic skip;
        logic err;
        logic done;
    } iord_core_state_type;

    iord_core_state_type state_reg;
    iord_core_state_type state_next;
    logic take;

    // A command is taken when none is outstanding and it is legal to send.
    always_comb
    begin
        logic bad;
        bad = 1'b0;
        // OUT writes to locations 0x00 to 0x02 are refused here rather than sent.
        bad = (cmd_op_i == IORD_OP_OUT && cmd_addr_i <= `IORD_IO_LAST
            && cmd_addr_i[5:0] < 6'h03);
        cmd_ready_o = !state_reg.busy;
        take = cmd_valid_i && !state_reg.busy && !bad;
        link.req = take;
        link.op = cmd_op_i;
        link.addr = cmd_addr_i;
        link.bit_sel = cmd_bit_i;
        link.wdata = cmd_wdata_i;
        state_next = state_reg;
        state_next.done = 1'b0;
        if (cmd_valid_i && !state_reg.busy && bad)
        begin
            state_next.done = 1'b1;
            state_next.err = 1'b1;
        end
        if (take)
        begin
            state_next.busy = 1'b1;
            state_next.op = cmd_op_i;
            state_next.want = cmd_wdata_i[0];
        end
        if (state_reg.busy && link.ack)
        begin
            state_next.busy = 1'b0;
            state_next.done = 1'b1;
            state_next.rdata = link.rdata;
            state_next.err = link.err;
            // Skip when the tested bit equals the wanted level.
            state_next.skip = !link.err && state_reg.op == IORD_OP_SKIPTEST
                && link.bit_val == state_reg.want;
        end
    end

    // State register.
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Answers come from state.
    always_comb
    begin
        done_o = state_reg.done;
        rdata_o = state_reg.rdata;
        skip_o = state_reg.skip;
        err_o = state_reg.err;
    end
endmodule : iord_core_end
`default_nettype wire

// ### iord_link_checker.sv
// Concurrent checks on the link between the core end and the bank.
// Assumes the bench places it beside the link, all on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module iord_link_checker
    import iord_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire iord_op_type op,
    input wire logic req,
    input wire logic [7:0] addr,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic bit_val,
    input wire logic ack,
    input wire logic err
);
    logic bit_high; // Bit access above the bit-accessible range.
    logic io_high; // I/O instruction past the 64 locations.
    logic ds_low; // Data-space access below the I/O window.
    assign bit_high = req && (op inside {IORD_OP_SETBIT, IORD_OP_CLRBIT, IORD_OP_SKIPTEST})
        && addr > 8'h1F;
    assign io_high = req && (op inside {IORD_OP_IN, IORD_OP_OUT}) && addr > 8'h3F;
    assign ds_low = req && (op inside {IORD_OP_LOAD, IORD_OP_STORE}) && addr < 8'h20;
    // Every check runs on the core clock and rests during reset.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    // The answer one cycle later, refused.
    sequence s_refused;
        ##1 (ack && err);
    endsequence
    // The answer one cycle later, taken.
    sequence s_taken;
        ##1 (ack && !err);
    endsequence
    a_ack_next: assert property (req |=> ack)
        else $error("link answer missing after a request");
    a_ack_cause: assert property (ack |-> $past(req))
        else $error("link answer without a request");
    a_err_in_ack: assert property (err |-> ack)
        else $error("refusal outside an answer");
    a_bit_range: assert property (bit_high |-> s_refused)
        else $error("bit access above range not refused");
    a_io_range: assert property (io_high |-> s_refused)
        else $error("I/O access past 64 locations not refused");
    a_ds_low: assert property (ds_low |-> s_refused)
        else $error("data access below window not refused");
    a_err_cause: assert property (err |-> $past(bit_high || io_high || ds_low))
        else $error("legal access refused");
    a_ext_load: assert property (req && op == IORD_OP_LOAD && addr >= 8'h60 |-> s_taken)
        else $error("extended region load refused");
    a_rsv_zero: assert property (req && op == IORD_OP_IN
        && addr inside {8'h00, 8'h01, 8'h02, 8'h0F, 8'h29} |=> rdata == 8'h00)
        else $error("reserved location read not zero");
    a_rsv_bits: assert property (req && op == IORD_OP_IN && addr == 8'h0E |=>
        rdata[7:4] == 4'h0)
        else $error("reserved bits read not zero");
    a_bit_answer: assert property (bit_val |-> ack && !err
        && $past(req && op == IORD_OP_SKIPTEST))
        else $error("tested bit level outside a skip answer");
endmodule : iord_link_checker
`default_nettype wire

// ### io_register_space_decode_tb.sv
// Self-checking bench: core end and bank joined by the link.
// Assumes the design files and checker compile before it.
`timescale 1ns/1ps
`default_nettype none
module io_register_space_decode_tb
    import iord_pkg::*;
;
    logic mclk_i, reset_i, cmd_valid_i, cmd_ready_o, done_o, skip_o, err_o;
    iord_op_type cmd_op_i;
    logic [7:0] cmd_addr_i, cmd_wdata_i, rdata_o, pin_b_i, pin_c_i, pin_d_i, ext_rdata_i;
    logic [2:0] cmd_bit_i, t0_event_i;
    logic [3:0] pin_a_i, t1_event_i, dir_a_o, out_a_o;
    logic [1:0] spi_status_i;
    logic [7:0] dir_b_o, out_b_o, dir_c_o, out_c_o, dir_d_o, out_d_o, ext_addr_o, ext_wdata_o;
    logic ext_we_o, ext_re_o;
    int err_total, checks, cycles;
    // Last strobe seen on the extended region, kept for the range checks.
    logic [7:0] ext_last_addr, ext_last_data;
    logic ext_last_rd;
    always @(posedge mclk_i)
    begin
        if (ext_we_o || ext_re_o)
        begin
            ext_last_addr <= ext_addr_o;
            ext_last_data <= ext_wdata_o;
            ext_last_rd <= ext_re_o;
        end
    end
    // Locations swept by the view test, with the bits each one keeps.
    logic [7:0] tbl_addr [0:22] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h0E,
        8'h12, 8'h1E, 8'h20, 8'h21, 8'h24, 8'h25, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h2C,
        8'h0F, 8'h17, 8'h29, 8'h3C};
    logic [7:0] tbl_mask [0:22] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h81, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00};
    iord_link_if link();
    iord_core_end i_iord_core_end (.mclk_i(mclk_i), .reset_i(reset_i), .link(link),
        .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
        .cmd_bit_i(cmd_bit_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
        .done_o(done_o), .rdata_o(rdata_o), .skip_o(skip_o), .err_o(err_o));
    iord_bank i_iord_bank (.mclk_i(mclk_i), .reset_i(reset_i), .link(link),
        .pin_b_i(pin_b_i), .pin_c_i(pin_c_i), .pin_d_i(pin_d_i), .pin_a_i(pin_a_i),
        .t0_event_i(t0_event_i), .t1_event_i(t1_event_i), .spi_status_i(spi_status_i),
        .dir_b_o(dir_b_o), .out_b_o(out_b_o), .dir_c_o(dir_c_o), .out_c_o(out_c_o),
        .dir_d_o(dir_d_o), .out_d_o(out_d_o), .dir_a_o(dir_a_o), .out_a_o(out_a_o),
        .ext_addr_o(ext_addr_o), .ext_we_o(ext_we_o), .ext_re_o(ext_re_o),
        .ext_wdata_o(ext_wdata_o), .ext_rdata_i(ext_rdata_i));
    iord_link_checker i_chk (.mclk_i(mclk_i), .reset_i(reset_i), .op(link.op),
        .req(link.req), .addr(link.addr), .bit_sel(link.bit_sel), .wdata(link.wdata),
        .rdata(link.rdata), .bit_val(link.bit_val), .ack(link.ack), .err(link.err));
    // Core clock, 5 ns period.
    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // Cuts a hung run short.
    always @(posedge mclk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 6000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One command: wait until ready, hold it over the taking edge, wait for done.
    task automatic access(input iord_op_type op, input logic [7:0] a, input logic [2:0] b,
        input logic [7:0] d);
        int n;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 20)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        cmd_valid_i = 1'b1;
        cmd_op_i = op;
        cmd_addr_i = a;
        cmd_bit_i = b;
        cmd_wdata_i = d;
        @(posedge mclk_i);
        #1;
        cmd_valid_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 20)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk("done", 8'(done_o), 8'h01);
    endtask : access
    // A read command followed by a check of its data.
    task automatic rd(input string what, input iord_op_type op, input logic [7:0] a,
        input logic [7:0] exp);
        access(op, a, 3'h0, 8'h00);
        chk(what, rdata_o, exp);
    endtask : rd
    // Main sequence of tests.
    initial
    begin
        reset_i = 1'b1;
        cmd_valid_i = 1'b0;
        cmd_op_i = IORD_OP_NONE;
        cmd_addr_i = 8'h00;
        cmd_bit_i = 3'h0;
        cmd_wdata_i = 8'h00;
        pin_b_i = 8'hC3;
        pin_c_i = 8'h3C;
        pin_d_i = 8'h99;
        pin_a_i = 4'h6;
        t0_event_i = 3'h0;
        t1_event_i = 4'h0;
        spi_status_i = 2'b11;
        ext_rdata_i = 8'h6E;
        err_total = 0;
        checks = 0;
        cycles = 0;
        repeat (20) @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        // Both views reach one register; reserved places keep zero.
        for (int i = 0; i < 23; i++)
        begin
            access(IORD_OP_OUT, tbl_addr[i], 3'h0, tbl_addr[i] ^ 8'hA5);
            rd("load view", IORD_OP_LOAD, tbl_addr[i] + 8'h20,
                (tbl_addr[i] ^ 8'hA5) & tbl_mask[i]);
            access(IORD_OP_STORE, tbl_addr[i] + 8'h20, 3'h0, tbl_addr[i] ^ 8'h5A);
            rd("in view", IORD_OP_IN, tbl_addr[i], (tbl_addr[i] ^ 8'h5A) & tbl_mask[i]);
        end
        chk("dir_b", dir_b_o, 8'h04 ^ 8'h5A);
        chk("dir_c", dir_c_o, 8'h5D);
        chk("out_c", out_c_o, 8'h52);
        chk("dir_d", dir_d_o, 8'h50);
        chk("out_d", out_d_o, 8'h51);
        chk("dir_a", 8'(dir_a_o), 8'h07);
        chk("out_a", 8'(out_a_o), 8'h04);
        access(IORD_OP_OUT, 8'h01, 3'h0, 8'hFF);
        chk("reserved write refused", 8'(err_o), 8'h01);
        rd("reserved read", IORD_OP_IN, 8'h01, 8'h00);
        rd("pins b", IORD_OP_IN, 8'h03, 8'hC3);
        rd("pins c", IORD_OP_LOAD, 8'h26, 8'h3C);
        rd("pins d", IORD_OP_IN, 8'h09, 8'h99);
        rd("pins a", IORD_OP_IN, 8'h0C, 8'h06);
        access(IORD_OP_OUT, 8'h2D, 3'h0, 8'hFF);
        rd("spi status", IORD_OP_IN, 8'h2D, 8'hC1);
        $display("test views finished");
        // Single-bit set and clear touch only the named bit.
        access(IORD_OP_OUT, 8'h05, 3'h0, 8'h00);
        access(IORD_OP_SETBIT, 8'h05, 3'h6, 8'h00);
        access(IORD_OP_SETBIT, 8'h05, 3'h3, 8'h00);
        chk("set bit", out_b_o, 8'h48);
        access(IORD_OP_CLRBIT, 8'h05, 3'h3, 8'h00);
        chk("clear bit", out_b_o, 8'h40);
        access(IORD_OP_SETBIT, 8'h20, 3'h0, 8'h00);
        chk("bit op above range", 8'(err_o), 8'h01);
        // Flags set by events, cleared by written ones.
        t0_event_i = 3'h7;
        t1_event_i = 4'h8;
        @(posedge mclk_i);
        #1;
        t0_event_i = 3'h0;
        t1_event_i = 4'h0;
        rd("t1 flags", IORD_OP_IN, 8'h16, 8'h20);
        access(IORD_OP_OUT, 8'h15, 3'h0, 8'h00);
        access(IORD_OP_OUT, 8'h15, 3'h0, 8'h02);
        rd("t0 flags", IORD_OP_IN, 8'h15, 8'h05);
        access(IORD_OP_SETBIT, 8'h15, 3'h0, 8'h00);
        rd("t0 after set bit", IORD_OP_IN, 8'h15, 8'h04);
        access(IORD_OP_CLRBIT, 8'h16, 3'h5, 8'h00);
        rd("t1 after clear bit", IORD_OP_IN, 8'h16, 8'h20);
        $display("test bits finished");
        // Skip tests follow the present bit level.
        access(IORD_OP_SKIPTEST, 8'h03, 3'h6, 8'h01);
        chk("skip set", 8'(skip_o), 8'h01);
        access(IORD_OP_SKIPTEST, 8'h03, 3'h2, 8'h01);
        chk("no skip", 8'(skip_o), 8'h00);
        access(IORD_OP_SKIPTEST, 8'h03, 3'h2, 8'h00);
        chk("skip clear", 8'(skip_o), 8'h01);
        access(IORD_OP_SKIPTEST, 8'h25, 3'h0, 8'h01);
        chk("skip above range", 8'(err_o), 8'h01);
        // Extended region by data space only; out-of-window refusals.
        rd("ext load", IORD_OP_LOAD, 8'h80, 8'h6E);
        chk("ext read strobe", 8'(ext_last_rd), 8'h01);
        chk("ext read address", ext_last_addr, 8'h80);
        access(IORD_OP_STORE, 8'hF0, 3'h0, 8'h11);
        chk("ext store", 8'(err_o), 8'h00);
        chk("ext write strobe", 8'(ext_last_rd), 8'h00);
        chk("ext write address", ext_last_addr, 8'hF0);
        chk("ext write data", ext_last_data, 8'h11);
        access(IORD_OP_OUT, 8'h90, 3'h0, 8'h77);
        chk("out to extended", 8'(err_o), 8'h01);
        chk("no ext strobe", ext_last_data, 8'h11);
        access(IORD_OP_IN, 8'h40, 3'h0, 8'h00);
        chk("in past window", 8'(err_o), 8'h01);
        access(IORD_OP_LOAD, 8'h10, 3'h0, 8'h00);
        chk("load below window", 8'(err_o), 8'h01);
        $display("test ranges finished");
        report_and_stop();
    end
endmodule : io_register_space_decode_tb
`default_nettype wire
